// >>> include/msb_defs.vh
// Constants for the multidrop scan bridge selection logic
`ifndef MSB_DEFS_VH
`define MSB_DEFS_VH
// Instruction register width and address field width
`define MSB_IR_W        8
`define MSB_ADDR_W      7
// Reserved level-1 codes (broadcast and four multicast groups)
`define MSB_BCAST_CODE  7'h3a
`define MSB_MCAST0_CODE 7'h3b
`define MSB_MCAST1_CODE 7'h3c
`define MSB_MCAST2_CODE 7'h3d
`define MSB_MCAST3_CODE 7'h3e
`define MSB_GRP_W       2
// Level-2 instruction codes (full IR value)
`define MSB_I_BYPASS    8'hff
`define MSB_I_EXTEST    8'h00
`define MSB_I_SAMPLE    8'h81
`define MSB_I_IDCODE    8'haa
`define MSB_I_MODE_REG_SELECT_CMD   8'h8e
`define MSB_I_GRPSEL    8'h03
`define MSB_I_SIGSEL    8'hc9
`define MSB_I_CNTSEL    8'hca
`define MSB_I_SIGON     8'h0c
`define MSB_I_SIGOFF    8'h8d
`define MSB_I_CNTON     8'h0f
`define MSB_I_CNTOFF    8'h90
`define MSB_I_WAIT      8'h84
`define MSB_I_PARKTLR   8'hc1
`define MSB_I_PARK_IN_IDLE_CMD   8'hc2
`define MSB_I_PARKPDR   8'hc3
`define MSB_I_PARKPIR   8'hc4
`define MSB_I_UNPARK    8'he2
// Width of the one-hot register select output
`define MSB_SEL_W       8
`endif

// >>> core/msb_bridge_select.v
// Selection, TAP and local port configuration logic of a scan bridge
// Operation
// - Compare low seven IR bits with slot
// - Broadcast or multicast match selects device
// - No match moves to unselected state
// - Shift-IR bits enter IR at MSB
// - Unselected device discards IR shift-out bits
// - Reset: TLR, wait-for-address, ports parked-TLR
// - Three port configuration machines moving in lockstep
// - Ports park in TLR, RTI, PDR, PIR
// - Parked-RTI unparks after unpark plus RTI
// - Park-RTI holds local TMS low
// - Port machines enabled only when selected
// - Group register writable only single-selected
// - Selected device decodes level-2 instructions
// - One chain; unparked ports inserted serially
// - Registers shift in at MSB
`timescale 1ns/10ps
`include "msb_defs.vh"
module msb_bridge_select (
  input  wire       clk,
  input  wire       rst,
  input  wire       tck_b,
  input  wire       tms_b,
  input  wire       tdi_b,
  output reg        tdo_b,
  output reg        tdo_b_oe,
  input  wire [6:0] slot,
  output wire [2:0] tck_lsp,
  output reg  [2:0] tms_lsp,
  output reg  [2:0] tdi_lsp,
  input  wire [2:0] tdo_lsp,
  output reg  [2:0] port_active,
  output reg  [1:0] sel_state,
  output reg  [3:0] tap_state,
  output reg  [7:0] reg_select,
  output reg        sig_enable,
  output reg        cnt_enable
);
  // ==========================================================
  // TAP state codes
  localparam TLR = 4'h0, RTI = 4'h1, SDS = 4'h2, CDR = 4'h3;
  localparam SDR = 4'h4, E1D = 4'h5, PDR = 4'h6, E2D = 4'h7;
  localparam UDR = 4'h8, SIS = 4'h9, CIR = 4'ha, SIR = 4'hb;
  localparam E1I = 4'hc, PIR = 4'hd, E2I = 4'he, UIR = 4'hf;
  // Selection states
  localparam S_WAIT = 2'h0, S_SINGLE = 2'h1, S_GROUP = 2'h2;
  localparam S_UNSEL = 2'h3;
  // Port configuration states
  localparam P_TLR = 3'h0, P_RTI = 3'h1, P_PDR = 3'h2, P_PIR = 3'h3;
  localparam P_ACT = 3'h4;

  // ==========================================================
  // Pin synchronisers; first stage feeds only the second
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg       tck_d;
  always @(posedge clk) begin
    if (rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      tck_d <= 1'b0;
    end else begin
      sync1 <= {tck_b, tms_b, tdi_b};
      sync2 <= sync1;
      tck_d <= sync2[2];
    end
  end
  wire tck_s = sync2[2];
  wire tms_s = sync2[1];
  wire tdi_s = sync2[0];
  wire rise  = tck_s & ~tck_d;
  wire fall  = ~tck_s & tck_d;
  // Local clocks follow the synchronised backplane clock
  assign tck_lsp = {3{tck_s}};

  // ==========================================================
  // TAP controller next state
  function [3:0] tap_next;
    input [3:0] s;
    input       m;
    begin
      case (s)
        TLR: tap_next = m ? TLR : RTI;
        RTI: tap_next = m ? SDS : RTI;
        SDS: tap_next = m ? SIS : CDR;
        CDR: tap_next = m ? E1D : SDR;
        SDR: tap_next = m ? E1D : SDR;
        E1D: tap_next = m ? UDR : PDR;
        PDR: tap_next = m ? E2D : PDR;
        E2D: tap_next = m ? UDR : SDR;
        UDR: tap_next = m ? SDS : RTI;
        SIS: tap_next = m ? TLR : CIR;
        CIR: tap_next = m ? E1I : SIR;
        SIR: tap_next = m ? E1I : SIR;
        E1I: tap_next = m ? UIR : PIR;
        PIR: tap_next = m ? E2I : PIR;
        E2I: tap_next = m ? UIR : SIR;
        UIR: tap_next = m ? SDS : RTI;
        default: tap_next = TLR;
      endcase
    end
  endfunction

  // Reserved group code test, used by the selection machine only
  function is_group;
    input [6:0] a;
    begin
      is_group = (a == `MSB_MCAST0_CODE) || (a == `MSB_MCAST1_CODE) ||
                 (a == `MSB_MCAST2_CODE) || (a == `MSB_MCAST3_CODE);
    end
  endfunction

  // ==========================================================
  // Registers
  reg  [7:0] ir_shift;
  reg  [7:0] ir;
  reg  [1:0] group_address_register;
  reg        grp_valid;
  reg  [1:0] grp_shift;
  reg        bypass_bit;
  reg  [2:0] pstate [0:2];
  wire [3:0] next_tap = tap_next(tap_state, tms_s);
  wire       selected = (sel_state == S_SINGLE) || (sel_state == S_GROUP);

  // TAP state register and IR shift/update
  always @(posedge clk) begin
    if (rst) begin
      tap_state <= TLR;
      ir_shift  <= `MSB_I_BYPASS;
      ir        <= `MSB_I_BYPASS;
    end else if (rise) begin
      tap_state <= next_tap;
      if (tap_state == CIR)
        ir_shift <= {6'h00, 2'h1};
      else if (tap_state == SIR)
        ir_shift <= {tdi_s, ir_shift[7:1]};
      if (tap_state == TLR)
        ir <= `MSB_I_BYPASS;
      else if (tap_state == UIR)
        ir <= ir_shift;
    end
  end

  // ==========================================================
  // Selection machine: decides at each IR update while unselected
  wire [6:0] addr = ir_shift[6:0];
  always @(posedge clk) begin
    if (rst) begin
      sel_state <= S_WAIT;
    end else if (rise) begin
      case (sel_state)
        S_WAIT, S_UNSEL: begin
          if (tap_state == UIR) begin
            if (addr == slot)
              sel_state <= S_SINGLE;
            else if (addr == `MSB_BCAST_CODE ||
                     (is_group(addr) && grp_valid &&
                      addr[1:0] + 2'h1 == group_address_register))
              sel_state <= S_GROUP;
            else
              sel_state <= S_UNSEL;
          // Leave on the same TCK edge that enters reset, not one later
          end else if (next_tap == TLR && sel_state == S_UNSEL)
            sel_state <= S_WAIT;
        end
        S_SINGLE, S_GROUP: begin
          if (tap_state == UIR && ir_shift == `MSB_I_WAIT)
            sel_state <= S_WAIT;
        end
        default: sel_state <= S_WAIT;
      endcase
    end
  end

  // ==========================================================
  // Level-2 decode; group register reachable only single-selected
  always @(posedge clk) begin
    if (rst) begin
      reg_select <= 8'h00;
      sig_enable <= 1'b0;
      cnt_enable <= 1'b0;
      group_address_register <= 2'h0;
      grp_valid  <= 1'b0;
      grp_shift  <= 2'h0;
      bypass_bit <= 1'b0;
    end else if (rise && selected && tap_state == UIR) begin
      reg_select <= 8'h00;
      case (ir_shift)
        `MSB_I_BYPASS:  reg_select <= 8'h01;
        `MSB_I_EXTEST,
        `MSB_I_SAMPLE:  reg_select <= 8'h02;
        `MSB_I_IDCODE:  reg_select <= 8'h04;
        `MSB_I_MODE_REG_SELECT_CMD: reg_select <= 8'h08;
        `MSB_I_GRPSEL:  reg_select <= {2'h0, sel_state == S_SINGLE, 5'h0};
        `MSB_I_SIGSEL:  reg_select <= 8'h40;
        `MSB_I_CNTSEL:  reg_select <= 8'h80;
        `MSB_I_SIGON:   sig_enable <= 1'b1;
        `MSB_I_SIGOFF:  sig_enable <= 1'b0;
        `MSB_I_CNTON:   cnt_enable <= 1'b1;
        `MSB_I_CNTOFF:  cnt_enable <= 1'b0;
        default:        reg_select <= 8'h01;
      endcase
    end else if (rise && tap_state == SDR) begin
      bypass_bit <= tdi_s;
      if (reg_select[5] && sel_state == S_SINGLE)
        grp_shift <= {tdi_s, grp_shift[1]};
    end else if (rise && tap_state == UDR && reg_select[5] &&
                 sel_state == S_SINGLE) begin
      group_address_register <= grp_shift;
      grp_valid <= 1'b1;
    end
  end

  // ==========================================================
  // Three port configuration machines
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : port
      reg [2:0] next_p;
      always @* begin
        next_p = pstate[g];
        if (selected) begin
          case (pstate[g])
            P_ACT: begin
              if (ir == `MSB_I_PARK_IN_IDLE_CMD && tap_state == RTI)
                next_p = P_RTI;
              else if (ir == `MSB_I_PARKTLR && tap_state == RTI)
                next_p = P_TLR;
              else if (ir == `MSB_I_PARKPDR && tap_state == PDR)
                next_p = P_PDR;
              else if (ir == `MSB_I_PARKPIR && tap_state == PIR)
                next_p = P_PIR;
            end
            P_TLR, P_RTI:
              if (ir == `MSB_I_UNPARK && tap_state == RTI)
                next_p = P_ACT;
            P_PDR:
              if (ir == `MSB_I_UNPARK && tap_state == PDR)
                next_p = P_ACT;
            P_PIR:
              if (ir == `MSB_I_UNPARK && tap_state == PIR)
                next_p = P_ACT;
            default: next_p = P_TLR;
          endcase
        end
      end
      always @(posedge clk) begin
        if (rst) begin
          pstate[g]      <= P_TLR;
          port_active[g] <= 1'b0;
          tms_lsp[g]     <= 1'b1;
        end else if (rise) begin
          pstate[g]      <= next_p;
          port_active[g] <= (next_p == P_ACT);
          // Parked-TLR holds TMS high, the other parks hold it low
          if (next_p == P_ACT)
            tms_lsp[g] <= tms_s;
          else
            tms_lsp[g] <= (next_p == P_TLR);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Serial chain through active ports; output changes on falling TCK
  reg [3:0] chain;
  always @* begin
    chain[0] = tdi_s;
    tdi_lsp  = 3'h0;
    chain[1] = port_active[0] ? tdo_lsp[0] : chain[0];
    tdi_lsp[0] = chain[0];
    chain[2] = port_active[1] ? tdo_lsp[1] : chain[1];
    tdi_lsp[1] = chain[1];
    chain[3] = port_active[2] ? tdo_lsp[2] : chain[2];
    tdi_lsp[2] = chain[2];
  end
  always @(posedge clk) begin
    if (rst) begin
      tdo_b    <= 1'b0;
      tdo_b_oe <= 1'b0;
    end else if (fall) begin
      // Unselected devices never drive; broadcast or multicast-selected devices drive too
      tdo_b_oe <= selected && (tap_state == SIR || tap_state == SDR);
      if (tap_state == SIR)
        tdo_b <= ir_shift[0];
      else if (|port_active)
        tdo_b <= chain[3];
      else if (reg_select[5])
        tdo_b <= grp_shift[0];
      else
        tdo_b <= bypass_bit;
    end
  end
endmodule // msb_bridge_select

// >>> testbench/msb_bridge_select_properties.sv
// Checker of the scan bridge selection logic, bound to its ports
`timescale 1ns/10ps
module msb_bridge_select_properties (
  input wire       clk,
  input wire       rst,
  input wire       tck_b,
  input wire       tms_b,
  input wire       tdi_b,
  input wire       tdo_b,
  input wire       tdo_b_oe,
  input wire [6:0] slot,
  input wire [2:0] tck_lsp,
  input wire [2:0] tms_lsp,
  input wire [2:0] tdi_lsp,
  input wire [2:0] tdo_lsp,
  input wire [2:0] port_active,
  input wire [1:0] sel_state,
  input wire [3:0] tap_state,
  input wire [7:0] reg_select,
  input wire       sig_enable,
  input wire       cnt_enable
);
  // ========================================================
  // Timing and sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Selection may only move on leaving update-IR or around reset of the TAP
  sequence s_sel_cause;
    $past(tap_state) == 4'hf || $past(tap_state) == 4'h0 || tap_state == 4'h0;
  endsequence
  // Two cycles in a row unselected
  sequence s_unsel_two;
    sel_state == 2'h3 ##1 sel_state == 2'h3;
  endsequence
  // ========================================================
  // Assertions
  a_reset_defaults: assert property (disable iff (1'b0) rst |=>
    tap_state == 4'h0 && sel_state == 2'h0 && port_active == 3'h0
    && tms_lsp == 3'h7 && !tdo_b_oe) else $error("reset state wrong");
  a_drive_when_selected: assert property (
    tdo_b_oe |-> sel_state == 2'h1 || sel_state == 2'h2)
    else $error("tdo driven while not selected");
  a_sel_on_update: assert property (
    $changed(sel_state) |-> s_sel_cause) else $error("selection moved early");
  a_unsel_frozen: assert property (
    s_unsel_two |-> $stable(port_active)) else $error("port moved unselected");
  a_unpark_needs_sel: assert property ($rose(port_active[0]) |->
    $past(sel_state) == 2'h1 || $past(sel_state) == 2'h2)
    else $error("port unparked while not selected");
  a_parked_held_low: assert property (
    (!port_active[0] && tms_lsp[0] == 1'b0) |=>
    (tms_lsp[0] == 1'b0 || port_active[0])) else $error("parked tms rose");
  a_select_onehot: assert property (
    $onehot0(reg_select)) else $error("register select not one-hot");
  a_group_single_only: assert property (
    reg_select[5] |-> sel_state == 2'h1) else $error("group reg reachable");
  a_tlr_releases: assert property (
    (sel_state == 2'h3 && tap_state == 4'h0) |-> ##[0:2] sel_state == 2'h0)
    else $error("unselected kept after reset state");
endmodule // msb_bridge_select_properties

bind msb_bridge_select msb_bridge_select_properties u_props (
  .clk, .rst, .tck_b, .tms_b, .tdi_b, .tdo_b, .tdo_b_oe, .slot, .tck_lsp,
  .tms_lsp, .tdi_lsp, .tdo_lsp, .port_active, .sel_state, .tap_state,
  .reg_select, .sig_enable, .cnt_enable);

// >>> testbench/msb_scan_tester.sv
// Model of the system scan tester on the backplane test port
`timescale 1ns/10ps
module msb_scan_tester (
  output reg tck,
  output reg tms,
  output reg tdi
);
  // ========================================================
  // Pins; TCK stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 125 ns TCK period; pins change while TCK is low
  task step(input m, input d);
    begin
      tms = m;
      tdi = d;
      #62.5 tck = 1'b1;
      #62.5 tck = 1'b0;
    end
  endtask
  // Pass through run-test/idle so a pending park or unpark lands
  task idle;
    step(1'b0, ~tdi);
  endtask
  // Five ones reach test-logic-reset from any state, then idle
  task go_idle;
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1) step(1'b1, ~tdi);
      idle;
    end
  endtask
  // Idle to shift-IR, eight bits LSB first, update, back to idle
  task ir_scan(input [7:0] v);
    integer i;
    begin
      step(1'b1, ~tdi);
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      step(1'b0, ~tdi);
      for (i = 0; i < 8; i = i + 1) step(i == 7, v[i]);
      step(1'b1, ~tdi);
      idle;
    end
  endtask
endmodule // msb_scan_tester

// >>> testbench/testbench.sv
// Self-checking bench of the scan bridge selection logic
`timescale 1ns/10ps
`include "msb_defs.vh"
module testbench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [6:0]  slot = 7'h05; // Not a reserved code
  reg  [2:0]  tdo_lsp = 3'h0;
  wire        tck_b, tms_b, tdi_b, tdo_b, tdo_b_oe, sig_enable, cnt_enable;
  wire [2:0]  tck_lsp, tms_lsp, tdi_lsp, port_active;
  wire [1:0]  sel_state;
  wire [3:0]  tap_state;
  wire [7:0]  reg_select;
  integer     mismatches = 0;
  integer     num_checks = 0;
  integer     i;
  reg  [63:0] codes = {`MSB_I_BYPASS, `MSB_I_SAMPLE, `MSB_I_EXTEST,
    `MSB_I_IDCODE, `MSB_I_MODE_REG_SELECT_CMD, `MSB_I_GRPSEL, `MSB_I_SIGSEL, `MSB_I_CNTSEL};
  reg  [63:0] sels = 64'h0102020408204080;
  // ========================================================
  // Clock, local chains and instances
  always #4 clk = ~clk;
  // Local chains as one stage each, returning inverted TDI one clk cycle later
  always @(posedge clk) tdo_lsp <= ~tdi_lsp;
  msb_scan_tester u_msb_scan_tester (.tck(tck_b), .tms(tms_b), .tdi(tdi_b));
  msb_bridge_select u_msb_bridge_select (.clk, .rst, .tck_b, .tms_b, .tdi_b,
    .tdo_b, .tdo_b_oe, .slot, .tck_lsp, .tms_lsp, .tdi_lsp, .tdo_lsp,
    .port_active, .sel_state, .tap_state, .reg_select, .sig_enable,
    .cnt_enable);
  // ========================================================
  // Shared tasks
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task ir(input [7:0] v);
    u_msb_scan_tester.ir_scan(v);
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ========================================================
  // Scenarios
  task t_reset;
    begin
      chk(tap_state, 8'h00);
      chk({sel_state, port_active, tms_lsp}, 8'h07);
      chk(tdo_b_oe, 8'h00);
      $display("t_reset done");
    end
  endtask
  // Foreign address, then level-2 traffic that must be ignored
  task t_miss;
    begin
      ir(8'h11);
      chk(sel_state, 8'h03);
      ir(`MSB_I_UNPARK);
      u_msb_scan_tester.idle;
      chk(port_active, 8'h00);
      u_msb_scan_tester.go_idle;
      chk(sel_state, 8'h00);
      $display("t_miss done");
    end
  endtask
  // Single selection, every register select, counters, park cycle
  task t_single;
    begin
      ir({1'b0, slot});
      chk(sel_state, 8'h01);
      for (i = 0; i < 8; i = i + 1) begin
        ir(codes[63-8*i -: 8]);
        chk(reg_select, sels[63-8*i -: 8]);
      end
      ir(`MSB_I_SIGON);
      ir(`MSB_I_CNTON);
      chk({sig_enable, cnt_enable}, 8'h03);
      ir(`MSB_I_SIGOFF);
      ir(`MSB_I_CNTOFF);
      chk({sig_enable, cnt_enable}, 8'h00);
      ir(`MSB_I_UNPARK);
      u_msb_scan_tester.idle;
      chk(port_active, 8'h07);
      ir(`MSB_I_PARK_IN_IDLE_CMD);
      u_msb_scan_tester.idle;
      chk({port_active, tms_lsp}, 8'h00);
      ir(`MSB_I_UNPARK);
      chk(port_active, 8'h00);
      u_msb_scan_tester.idle;
      chk(port_active, 8'h07);
      ir(`MSB_I_WAIT);
      chk(sel_state, 8'h00);
      $display("t_single done");
    end
  endtask
  // Broadcast selection: ports obey, group register stays out of reach
  task t_bcast;
    begin
      ir({1'b0, `MSB_BCAST_CODE});
      chk(sel_state, 8'h02);
      ir(`MSB_I_GRPSEL);
      chk(reg_select, 8'h00);
      ir(`MSB_I_PARK_IN_IDLE_CMD);
      u_msb_scan_tester.idle;
      chk(port_active, 8'h00);
      ir(`MSB_I_WAIT);
      chk(sel_state, 8'h00);
      $display("t_bcast done");
    end
  endtask
  // Program group 2 while single, then multicast hit and miss
  task t_group;
    begin
      ir({1'b0, slot});
      ir(`MSB_I_GRPSEL);
      u_msb_scan_tester.step(1'b1, 1'b0);
      u_msb_scan_tester.step(1'b0, 1'b0);
      u_msb_scan_tester.step(1'b0, 1'b0);
      #40;
      chk(tdo_b_oe, 8'h01);
      u_msb_scan_tester.step(1'b0, 1'b0);
      u_msb_scan_tester.step(1'b1, 1'b1);
      u_msb_scan_tester.step(1'b1, 1'b0);
      u_msb_scan_tester.idle;
      ir(`MSB_I_WAIT);
      chk(sel_state, 8'h00);
      ir({1'b0, `MSB_MCAST2_CODE});
      chk(sel_state, 8'h02);
      ir(`MSB_I_WAIT);
      ir({1'b0, `MSB_MCAST1_CODE});
      chk(sel_state, 8'h03);
      u_msb_scan_tester.go_idle;
      chk(sel_state, 8'h00);
      $display("t_group done");
    end
  endtask
  // ========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    u_msb_scan_tester.go_idle;
    t_miss;
    t_single;
    t_group;
    t_bcast;
    report_and_stop;
  end
  // Tests need about 55 us; a hang is cut off well beyond that
  initial begin
    #300000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
endmodule // testbench
